// [dv/oscst_ext_src.sv]
// External clock source model: crystal, RC network or clock oscillator.
// Assumes the block samples the pin on its own clock; the pin idles low.
`default_nettype none
module oscst_ext_src (
  input  wire logic        run_i,
  input  wire logic [15:0] half_ns_i,
  output logic             pin_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // Square wave only while enabled, at the full source rate with no divider
  initial begin
    pin_o = 1'b0;
    forever begin
      if (run_i !== 1'b1) begin
        pin_o = 1'b0;
        @(posedge run_i);
        #13;  // Phase offset against the system clock
      end
      #(half_ns_i);
      pin_o = ~pin_o;
    end
  end
endmodule // oscst_ext_src
`default_nettype wire

// [dv/tb.sv]
// Testbench for the oscillator clock select and trim block.
// Assumes oscst_top on classic Wishbone and an external clock source model.
`default_nettype none
module tb
  import oscst_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0] STORED_TRIM = 8'h9c;  // Stand-in factory trim value
  localparam int         BASE [4]    = '{40, 20, 12, 12};
  localparam int         DEF  [4]    = '{24, 48, 96, 24};
  localparam logic [7:0] TRIMS [3]   = '{8'h00, 8'hff, STORED_TRIM};
  logic             clk_i, rst_i, wait_mode_i, osc_in, ext_run;
  logic             wb_ack_o, pin_o, pin_oe, quad, dbl, bus_en, wd_en;
  logic [15:0]      ext_half;
  logic [31:0]      wb_dat_o, rd;
  logic [3:0]       obs;
  oscst_wb_req_type req;
  int               n_mismatch, check_count, p, h;
  assign obs = {wd_en, bus_en, dbl, quad};
  oscst_top u_oscst_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(req.cyc), .wb_stb_i(req.stb),
    .wb_we_i(req.we), .wb_adr_i(req.adr), .wb_sel_i(req.sel), .wb_dat_i(req.dat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .first_osc_pin_i(osc_in), .second_osc_pin_i(1'b0),
    .wait_mode_i(wait_mode_i), .second_osc_pin_o(pin_o), .second_osc_pin_oe_o(pin_oe),
    .quad_bus_clock_o(quad), .double_bus_clock_o(dbl), .bus_clock_en_o(bus_en),
    .watchdog_clock_en_o(wd_en));
  oscst_ext_src u_oscst_ext_src (.run_i(ext_run), .half_ns_i(ext_half), .pin_o(osc_in));
  // System clock, 50 ns period
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  // Compare and count
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  // One classic Wishbone cycle, held until ack is sampled
  task automatic wb(input logic we, input logic [3:0] a, input logic [7:0] d);
    req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hf, dat: {24'h0, d}};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    req.cyc <= 1'b0;
    req.stb <= 1'b0;
    @(posedge clk_i);
  endtask
  // Cycles between the second and third rising edges of one observed output
  task automatic period(input int i, output int per);
    int   n = 0;
    int   e = 0;
    int   t = 0;
    logic prv = 1'b1;
    per = 0;
    while (e < 3 && t < 3000) begin
      @(posedge clk_i);
      #1;
      t++;
      n++;
      if (obs[i] === 1'b1 && prv !== 1'b1) begin
        e++;
        per = n;
        n = 0;
      end
      prv = obs[i];
    end
  endtask
  // Internal oscillator quad period against select code and trim
  task automatic int_check(input logic [1:0] c, input logic [7:0] t);
    h = (BASE[c] * 16 + int'(t) - 128 + 8) / 16;
    period(0, p);
    chk("quad period", p, 2 * h);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Hang guard
  initial begin
    repeat (60000) @(posedge clk_i);
    n_mismatch++;
    close_out();
  end
  // Main sequence
  initial begin
    req = '0;
    wait_mode_i = 1'b0;
    ext_run = 1'b0;
    ext_half = 16'd350;
    rst_i = 1'b1;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, OSCST_SRC_CTRL_OFF, 8'h00);
    chk("src ctrl reset", rd, 32'h20);
    wb(1'b0, OSCST_TRIM_OFF, 8'h00);
    chk("trim reset", rd, 32'h80);
    wb(1'b1, 4'hc, 8'h5a);
    wb(1'b0, 4'hc, 8'h00);
    chk("unmapped read", rd, 32'h0);
    for (int i = 0; i < 4; i++) begin
      period(i, p);
      chk("default clock", p, DEF[i]);
    end
    $display("test reset defaults done");
    for (int c = 0; c < 4; c++) begin
      wb(1'b1, OSCST_SRC_CTRL_OFF, {2'b00, c[1:0], 4'h0});
      int_check(c[1:0], 8'h80);
    end
    wb(1'b1, OSCST_SRC_CTRL_OFF, 8'h20);
    foreach (TRIMS[k]) begin
      wb(1'b1, OSCST_TRIM_OFF, TRIMS[k]);
      wb(1'b0, OSCST_TRIM_OFF, 8'h00);
      chk("trim readback", rd, {24'h0, TRIMS[k]});
      int_check(2'b10, TRIMS[k]);
    end
    $display("test frequency and trim done");
    wb(1'b1, OSCST_SRC_CTRL_OFF, 8'h22);
    wb(1'b0, OSCST_SRC_CTRL_OFF, 8'h00);
    chk("src ctrl readback", rd, 32'h22);
    chk("pin enable", pin_oe, 1'b1);
    repeat (30) begin
      @(posedge clk_i);
      #1;
      chk("pin level", pin_o, quad);
    end
    wait_mode_i <= 1'b1;
    period(0, p);
    chk("wait quad", p, 28);
    period(1, p);
    chk("wait double", p, 56);
    wait_mode_i <= 1'b0;
    $display("test pin output and wait done");
    for (int o = 1; o < 4; o++) begin
      wb(1'b1, OSCST_SRC_CTRL_OFF, {o[1:0], 6'b100110});
      ext_run <= 1'b1;
      period(0, p);
      chk("external quad", p, 14);
      period(3, p);
      chk("external watchdog", p, 14);
      chk("pin enable off", pin_oe, 1'b0);
      ext_run <= 1'b0;
    end
    $display("test external sources done");
    close_out();
  end
endmodule // tb
`default_nettype wire

// [hw/oscst_intosc.sv]
// Model of the trimmable internal oscillator as a clock enable generator.
// Assumes one synchronous clock; period grows with larger trim value.
`default_nettype none
module oscst_intosc
  import oscst_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [1:0] freq_sel_i,
  input  wire logic [7:0] trim_i,
  output logic            tick_o
);
  logic [7:0]  half_base;
  logic [11:0] half_len;
  logic [11:0] count_q;
  logic [11:0] count_d;
  logic [11:0] half_cyc;
  logic        hit;

  // Half period from the frequency select
  assign half_base = (freq_sel_i == OSCST_ICF_4M0) ? OSCST_HALF_4M0 :
                     (freq_sel_i == OSCST_ICF_8M0) ? OSCST_HALF_8M0 :
                     OSCST_HALF_12M8; // Reserved code treated as 12.8 MHz
  // Larger trim, longer period; 0x80 is nominal
  assign half_len = 12'({half_base, 4'h0}) + 12'(trim_i) - 12'(OSCST_TRIM_RST);
  // Half period in system clocks, rounded from sixteenths
  assign half_cyc = (half_len + 12'(1 << (OSCST_TRIM_SHIFT - 1))) >> OSCST_TRIM_SHIFT;
  // At or past the end, so a shorter setting never waits for a wrap
  assign hit      = (count_q >= (half_cyc - 12'h001));
  assign count_d  = hit ? 12'h000 : count_q + 12'h001;
  assign tick_o   = hit;

  // Period counter
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_q <= 12'h000;
    end else begin
      count_q <= count_d;
    end
  end
endmodule // oscst_intosc
`default_nettype wire

// [hw/oscst_pkg.sv]
// Package for the oscillator clock select and trim block.
// Assumes a 20 MHz system clock and a classic Wishbone register port.
`default_nettype none
package oscst_pkg;
  // Register byte offsets
  localparam logic [3:0] OSCST_SRC_CTRL_OFF  = 4'h0;
  localparam logic [3:0] OSCST_TRIM_OFF      = 4'h4;
  localparam logic [3:0] OSCST_STATUS_OFF    = 4'h8;
  // Source control fields
  localparam int OSCST_OPT_MSB  = 7;
  localparam int OSCST_OPT_LSB  = 6;
  localparam int OSCST_ICF_MSB  = 5;
  localparam int OSCST_ICF_LSB  = 4;
  localparam int OSCST_XR_MSB   = 3;
  localparam int OSCST_XR_LSB   = 2;
  localparam int OSCST_OE_BIT   = 1;
  // Reset values
  localparam logic [7:0] OSCST_SRC_CTRL_RST = 8'h20;
  localparam logic [7:0] OSCST_TRIM_RST     = 8'h80;
  // Clock source codes
  typedef enum logic [1:0] {
    OSCST_SRC_INT  = 2'b00,
    OSCST_SRC_EXT  = 2'b01,
    OSCST_SRC_RC   = 2'b10,
    OSCST_SRC_XTAL = 2'b11
  } oscst_src_type;
  // Internal frequency codes
  localparam logic [1:0] OSCST_ICF_4M0  = 2'b00;
  localparam logic [1:0] OSCST_ICF_8M0  = 2'b01;
  localparam logic [1:0] OSCST_ICF_12M8 = 2'b10;
  localparam logic [1:0] OSCST_ICF_RSVD = 2'b11;
  // Internal oscillator half periods in system clocks at nominal trim
  localparam logic [7:0] OSCST_HALF_4M0  = 8'h28;
  localparam logic [7:0] OSCST_HALF_8M0  = 8'h14;
  localparam logic [7:0] OSCST_HALF_12M8 = 8'h0c;
  localparam int         OSCST_TRIM_SHIFT = 4;
  // Wishbone request carrier
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } oscst_wb_req_type;
endpackage : oscst_pkg
`default_nettype wire

// [hw/oscst_top.sv]
// Oscillator clock select and trim: root select, x4/x2/bus clock enables.
// Assumes classic Wishbone, external clock pins sampled on clk_i.
//
// Chosen here: the Wishbone interface to the registers and the register offsets.
`default_nettype none
module oscst_top
  import oscst_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        first_osc_pin_i,
  input  wire logic        second_osc_pin_i,
  input  wire logic        wait_mode_i,
  output logic             second_osc_pin_o,
  output logic             second_osc_pin_oe_o,
  output logic             quad_bus_clock_o,
  output logic             double_bus_clock_o,
  output logic             bus_clock_en_o,
  output logic             watchdog_clock_en_o
);
  oscst_wb_req_type req;
  logic [7:0]  src_ctrl_q;
  logic [7:0]  trim_q;
  logic        ack_q;
  logic [31:0] rdat_q;
  logic [31:0] rdat_d;
  logic [2:0]  pin1_sync_q;
  logic [1:0]  pin2_sync_q;
  logic        quad_q;
  logic        dbl_q;
  logic        bus_q;
  logic        quad_prev_q;
  logic        dbl_prev_q;
  logic        bus_en_q;
  logic [7:0]  quad_edges_q;

  // Request bundle
  assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i,
                 adr: wb_adr_i, sel: wb_sel_i, dat: wb_dat_i};

  // Decode
  wire         access   = req.cyc && req.stb && !ack_q;
  // Write lands at the edge after the one that presents ack, where the master samples it
  wire         wr       = req.cyc && req.stb && ack_q && req.we && req.sel[0];
  wire         hit_src  = (req.adr == OSCST_SRC_CTRL_OFF);
  wire         hit_trim = (req.adr == OSCST_TRIM_OFF);
  wire         hit_stat = (req.adr == OSCST_STATUS_OFF);
  wire [1:0]   src_opt  = src_ctrl_q[OSCST_OPT_MSB:OSCST_OPT_LSB];
  wire [1:0]   icf      = src_ctrl_q[OSCST_ICF_MSB:OSCST_ICF_LSB];
  wire         pin2_oe  = src_ctrl_q[OSCST_OE_BIT];
  oscst_src_type src_sel;
  assign src_sel = oscst_src_type'(src_opt);

  // Read data mux; unmapped reads as zero
  always_comb begin
    rdat_d = 32'h0000_0000;
    if (hit_src) begin
      rdat_d = {24'h000000, src_ctrl_q};
    end else if (hit_trim) begin
      rdat_d = {24'h000000, trim_q};
    end else if (hit_stat) begin
      rdat_d = {24'h000000, quad_edges_q};
    end
  end

  // Register writes; trim only by software
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      src_ctrl_q <= OSCST_SRC_CTRL_RST; // Internal osc, 12.8 MHz
      trim_q     <= OSCST_TRIM_RST;
    end else if (wr && hit_src) begin
      src_ctrl_q <= {req.dat[7:1], 1'b0};  // Option, freq, range, pin enable
    end else if (wr && hit_trim) begin
      trim_q <= req.dat[7:0];
    end
  end

  // Bus answer one cycle after request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      ack_q  <= access;
      rdat_q <= rdat_d;
    end
  end
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  // Pin synchronisers; third stage only for edge detection
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin1_sync_q <= 3'b000;
      pin2_sync_q <= 2'b00;
    end else begin
      pin1_sync_q <= {pin1_sync_q[1:0], first_osc_pin_i};
      pin2_sync_q <= {pin2_sync_q[0], second_osc_pin_i};
    end
  end

  // Internal oscillator model
  logic int_tick;
  oscst_intosc u_intosc (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .freq_sel_i (icf),
    .trim_i     (trim_q),
    .tick_o     (int_tick)
  );

  // Root edges: external clock, RC and crystal all enter on the first pin
  wire ext_rise = pin1_sync_q[1] && !pin1_sync_q[2];
  wire ext_fall = !pin1_sync_q[1] && pin1_sync_q[2];
  // Crystal taken undivided from the pin
  wire root_toggle = (src_sel == OSCST_SRC_INT) ? int_tick : (ext_rise || ext_fall);

  // Quad clock tracks root; double and bus divide by two; wait ignored
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      quad_q      <= 1'b0;
      dbl_q       <= 1'b0;
      bus_q       <= 1'b0;
      quad_prev_q <= 1'b0;
      dbl_prev_q  <= 1'b0;
    end else begin
      quad_prev_q <= quad_q;
      dbl_prev_q  <= dbl_q;
      if (root_toggle) begin
        quad_q <= !quad_q;
      end
      if (quad_q && !quad_prev_q) begin
        dbl_q <= !dbl_q;
      end
      if (dbl_q && !dbl_prev_q) begin
        bus_q <= !bus_q;
      end
    end
  end

  // Bus clock enable pulse and quad edge counter for the status register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_en_q     <= 1'b0;
      quad_edges_q <= 8'h00;
    end else begin
      bus_en_q <= (dbl_q && !dbl_prev_q) && !bus_q;
      if (quad_q && !quad_prev_q) begin
        quad_edges_q <= quad_edges_q + 8'h01;
      end
    end
  end

  assign quad_bus_clock_o    = quad_q;
  assign double_bus_clock_o  = dbl_q;
  assign bus_clock_en_o      = bus_en_q;
  assign watchdog_clock_en_o = quad_q && !quad_prev_q;
  // Second pin shows quad clock when enabled and the internal oscillator is selected
  assign second_osc_pin_o    = quad_q;
  assign second_osc_pin_oe_o = pin2_oe && (src_sel == OSCST_SRC_INT);

  // Checks
  a_reset_defaults: assert property (@(posedge clk_i) $past(rst_i) |->
    src_ctrl_q == OSCST_SRC_CTRL_RST && trim_q == OSCST_TRIM_RST)
    else $error("bad reset value");
  a_dbl_half_quad: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(dbl_q) |-> $past(quad_q) && !$past(quad_prev_q))
    else $error("double not from quad");
  a_bus_half_dbl: assert property (@(posedge clk_i) disable iff (rst_i)
    $changed(bus_q) |-> $past(dbl_q) && !$past(dbl_prev_q))
    else $error("bus not from double");
  a_quad_follows_root: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(root_toggle) |-> quad_q != $past(quad_q))
    else $error("quad missed root");
  a_pin_drive: assert property (@(posedge clk_i) disable iff (rst_i)
    second_osc_pin_oe_o |-> pin2_oe && second_osc_pin_o == quad_q)
    else $error("pin drive wrong");
  a_trim_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
    !(wr && hit_trim) |=> trim_q == $past(trim_q))
    else $error("trim changed by itself");
  a_wait_ignored: assert property (@(posedge clk_i) disable iff (rst_i)
    wait_mode_i && $past(root_toggle) |-> quad_q != $past(quad_q))
    else $error("wait stopped clock");
  a_ack_one: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held");
  c_src_xtal: cover property (@(posedge clk_i) src_sel == OSCST_SRC_XTAL && ext_rise);
  c_trim_write: cover property (@(posedge clk_i) wr && hit_trim);
  c_bus_tick: cover property (@(posedge clk_i) bus_en_q);
endmodule // oscst_top
`default_nettype wire
